//--- rtl/smb_pkg.sv
// Package of constants and carrier types for the system memory bus interface
package smb_pkg;

	// Address windows for the chip selects
	localparam logic [31:0] PROM_BASE  = 32'h1f00_0000;
	localparam logic [31:0] PROM_LAST  = 32'h1fff_ffff;
	localparam logic [31:0] IO_BASE    = 32'h1e00_0000;
	localparam logic [31:0] IO_LAST    = 32'h1eff_ffff;

	// Data path geometry
	localparam int DATA_W     = 32;
	localparam int LANES      = 4;
	localparam int NARROW_BEATS = 4;
	localparam int FIFO_DEPTH = 8;

	// Default wait-state count and its counter width
	localparam int          WAIT_W       = 4;
	localparam logic [3:0]  WAIT_DEFAULT = 4'h3;

	// Request from the core side
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
		logic        write;
		logic        dram;
	} smb_req_t;

	// Read answer to the core side
	typedef struct packed {
		logic [31:0] rdata;
		logic        perr;
	} smb_rsp_t;

	localparam int REQ_W = $bits(smb_req_t);
	localparam int RSP_W = $bits(smb_rsp_t);

	// Bus sequencer states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_ROW   = 5'b00010,
		ST_COL   = 5'b00100,
		ST_WAIT  = 5'b01000,
		ST_DONE  = 5'b10000
	} smb_state_t;

endpackage

//--- rtl/smb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module smb_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             nrst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// Honest flags straight from the count
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage write
	always_ff @(posedge clock)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	// Pointers and occupancy
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

//--- rtl/smb_bus_if.sv
// System memory bus interface: sequencer, strobes, parity, chip selects
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] Byte-wide peripherals sit on one byte lane
// [R2] Narrow port reads take bits 7:0
// [R3] Mux select high row, low column
// [R4] DRAM output enable when DRAM drives data
// [R5] Even parity per byte lane
// [R6] Always generate; check only when enabled
// [R7] Parity error flagged, status posted
// [R8] Row strobe marks row address phase
// [R9] Transaction holds until ready
// [R10] Auto wait states end chip-selected cycles
// [R11] Early external ready ends cycle early
// [R12] PROM select over its window
// [R13] I/O select over its window
// [R14] Start strobe low one cycle
// [R15] Narrow-port logic never enables parity check
// [R16] Read strobe during read transactions
// [R17] DMA read strobe drives DRAM output enable
// [R18] Read-cycle output high-active for reads; the code drives read_cycle_out_n low for reads
// [R19] Watch read-cycle input while not master
// [R20] Cache test master drives read-cycle input
// [R21] Byte write strobes only for valid lanes
// [R22] Narrow reads run four wrapping byte cycles
// [R23] Column strobe marks column address phase
// [R24] Parity error one cycle after ready
module smb_bus_if #(
	parameter int WAIT_W = smb_pkg::WAIT_W
) (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  nrst,
	// Core request stream
	input  wire logic                  req_valid,
	output logic                       req_ready,
	input  wire smb_pkg::smb_req_t     req,
	// Read answer stream
	output logic                       rsp_valid,
	input  wire logic                  rsp_ready,
	output smb_pkg::smb_rsp_t          rsp,
	// Wait-state control and status
	input  wire logic                  auto_wait_en,
	input  wire logic [WAIT_W-1:0]     wait_count,
	output logic                       parity_status,
	// Bus ownership and snooping
	input  wire logic                  bus_granted,
	input  wire logic                  snoop_cacheable_n,
	input  wire logic                  snoop_strobe_n,
	output logic                       snoop_invalidate,
	// Memory bus outputs
	output logic [31:0]                addr_out,
	output logic [31:0]                data_out,
	output logic                       data_out_en_n,
	output logic [3:0]                 parity_out,
	output logic                       transaction_start_n,
	output logic                       read_strobe_out_n,
	output logic                       read_cycle_out_n,
	output logic [3:0]                 byte_write_strobes_n,
	output logic                       boot_prom_select_n,
	output logic                       io_window_select_n,
	output logic                       parity_error,
	// DRAM control
	output logic                       dram_row_col_select,
	output logic                       dram_output_enable_n,
	output logic                       dram_row_strobe_n,
	output logic                       dram_col_strobe_n,
	// Memory bus inputs (pins)
	input  wire logic [31:0]           data_in,
	input  wire logic [3:0]            parity_in,
	input  wire logic                  transfer_ready_n,
	input  wire logic                  parity_check_enable_n,
	input  wire logic                  narrow_port_n,
	input  wire logic                  read_strobe_in_n,
	input  wire logic                  read_cycle_in_n
);

	// Even parity bit for one byte
	function automatic logic byte_par(input logic [7:0] b);
		byte_par = ^b;
	endfunction

	// Per-lane parity of a word
	function automatic logic [3:0] word_par(input logic [31:0] w);
		for (int i = 0; i < 4; i++)
			word_par[i] = byte_par(w[8*i +: 8]);
	endfunction

	// Pin synchronisers: three stages, second and third must agree
	logic [2:0] rdy_s;
	logic [2:0] pen_s;
	logic [2:0] nar_s;
	logic [2:0] rdi_s;
	logic [2:0] rti_s;
	logic [2:0] csh_s;
	logic [2:0] sst_s;
	logic       rdy_q;
	logic       pen_q;
	logic       nar_q;
	logic       rdi_q;
	logic       rti_q;
	logic       csh_q;
	logic       sst_q;

	// Synchronise control pins; filtered level updates on agreement
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			rdy_s <= 3'h7;
			pen_s <= 3'h7;
			nar_s <= 3'h7;
			rdi_s <= 3'h7;
			rti_s <= 3'h7;
			csh_s <= 3'h7;
			sst_s <= 3'h7;
			rdy_q <= 1'b1;
			pen_q <= 1'b1;
			nar_q <= 1'b1;
			rdi_q <= 1'b1;
			rti_q <= 1'b1;
			csh_q <= 1'b1;
			sst_q <= 1'b1;
		end
		else
		begin
			rdy_s <= {rdy_s[1:0], transfer_ready_n};
			pen_s <= {pen_s[1:0], parity_check_enable_n};
			nar_s <= {nar_s[1:0], narrow_port_n};
			rdi_s <= {rdi_s[1:0], read_strobe_in_n};
			rti_s <= {rti_s[1:0], read_cycle_in_n};
			csh_s <= {csh_s[1:0], snoop_cacheable_n};
			sst_s <= {sst_s[1:0], snoop_strobe_n};
			if (rdy_s[1] == rdy_s[2])
				rdy_q <= rdy_s[2];
			if (pen_s[1] == pen_s[2])
				pen_q <= pen_s[2];
			if (nar_s[1] == nar_s[2])
				nar_q <= nar_s[2];
			if (rdi_s[1] == rdi_s[2])
				rdi_q <= rdi_s[2];
			if (rti_s[1] == rti_s[2])
				rti_q <= rti_s[2];
			if (csh_s[1] == csh_s[2])
				csh_q <= csh_s[2];
			if (sst_s[1] == sst_s[2])
				sst_q <= sst_s[2];
		end
	end

	// Request FIFO: back-pressure reaches the core through req_ready
	logic                 fifo_valid;
	logic                 fifo_take;
	smb_pkg::smb_req_t    cur;

	smb_fifo #(
		.WIDTH (smb_pkg::REQ_W),
		.DEPTH (smb_pkg::FIFO_DEPTH)
	) u_req_fifo (
		.clock     (clock),
		.nrst      (nrst),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.in_data   (req),
		.out_valid (fifo_valid),
		.out_ready (fifo_take),
		.out_data  (cur)
	);

	smb_pkg::smb_state_t  st_q;
	smb_pkg::smb_req_t    hold_q;
	logic [WAIT_W-1:0]    wcnt_q;
	logic [1:0]           beat_q;
	logic                 narrow_q;
	logic                 cs_q;
	logic [31:0]          rbuf_q;
	logic                 perr_acc_q;
	logic                 ready_now;
	logic                 last_beat;
	logic [1:0]           lane;
	logic                 in_prom;
	logic                 in_io;

	// Window decode of the next request
	assign in_prom = (cur.addr >= smb_pkg::PROM_BASE) &&
		(cur.addr <= smb_pkg::PROM_LAST);
	assign in_io   = (cur.addr >= smb_pkg::IO_BASE) &&
		(cur.addr <= smb_pkg::IO_LAST);

	// Start only when idle, owning the bus and the answer slot is free;
	// a ready still held from the last access must drop first, or it
	// would end the next access at once (a ready tied low stalls here)
	assign fifo_take = (st_q == smb_pkg::ST_IDLE) && fifo_valid &&
		!bus_granted && !rsp_valid && rdy_q;

	// [R9] [R11] ready ends cycle
	// External ready always wins; counter expiry ends chip-selected cycles
	assign ready_now = !rdy_q ||
		// [R10] auto wait expiry
		(auto_wait_en && cs_q && (wcnt_q == wait_count));
	assign last_beat = !narrow_q || (beat_q == 2'h3);
	// [R22] Lane of the current narrow beat, wrapping within the word
	assign lane      = hold_q.addr[1:0] + beat_q;

	// Transaction sequencer
	always_ff @(posedge clock)
	begin
		if (!nrst)
			st_q <= smb_pkg::ST_IDLE;
		else
		begin
			unique case (st_q)
				smb_pkg::ST_IDLE:
					if (fifo_take)
						st_q <= cur.dram ? smb_pkg::ST_ROW : smb_pkg::ST_WAIT;
				smb_pkg::ST_ROW:
					st_q <= smb_pkg::ST_COL;
				smb_pkg::ST_COL:
					st_q <= smb_pkg::ST_WAIT;
				smb_pkg::ST_WAIT:
					if (ready_now)
						st_q <= last_beat ? smb_pkg::ST_DONE :
							(hold_q.dram ? smb_pkg::ST_ROW : smb_pkg::ST_WAIT);
				smb_pkg::ST_DONE:
					st_q <= smb_pkg::ST_IDLE;
				default:
					st_q <= smb_pkg::ST_IDLE;
			endcase
		end
	end

	// Transaction context, beat and wait counters
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			hold_q   <= '0;
			wcnt_q   <= '0;
			beat_q   <= 2'h0;
			narrow_q <= 1'b0;
			cs_q     <= 1'b0;
		end
		else if (fifo_take)
		begin
			hold_q   <= cur;
			wcnt_q   <= '0;
			beat_q   <= 2'h0;
			// [R22] narrow read, writes ignore it
			narrow_q <= !nar_q && !cur.write;
			cs_q     <= in_prom || in_io;
		end
		else if (st_q == smb_pkg::ST_WAIT)
		begin
			if (ready_now)
			begin
				wcnt_q <= '0;
				beat_q <= beat_q + 2'h1;
			end
			else if (wcnt_q != wait_count)
				wcnt_q <= wcnt_q + 1'b1;
		end
	end

	// Address and write data; narrow beats wrap within the word
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			addr_out      <= '0;
			data_out      <= '0;
			parity_out    <= 4'h0;
			data_out_en_n <= 1'b1;
		end
		else if (fifo_take)
		begin
			addr_out      <= cur.addr;
			data_out      <= cur.wdata;
			// [R5] [R6] parity generated with writes
			parity_out    <= word_par(cur.wdata);
			data_out_en_n <= !cur.write;
		end
		else if (st_q == smb_pkg::ST_WAIT && ready_now && !last_beat)
			// [R22] next wrapped byte address
			addr_out[1:0] <= lane + 2'h1;
		else if (st_q == smb_pkg::ST_DONE)
			data_out_en_n <= 1'b1;
	end

	// Strobes and chip selects, registered straight to the pins
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			transaction_start_n  <= 1'b1;
			read_strobe_out_n    <= 1'b1;
			read_cycle_out_n     <= 1'b1;
			byte_write_strobes_n <= 4'hf;
			boot_prom_select_n   <= 1'b1;
			io_window_select_n   <= 1'b1;
		end
		else if (fifo_take)
		begin
			// [R14] one-cycle start strobe
			transaction_start_n  <= 1'b0;
			// [R16] [R18] read indications
			read_strobe_out_n    <= cur.write;
			read_cycle_out_n     <= cur.write;
			// [R21] only lanes with valid data
			byte_write_strobes_n <= cur.write ? ~cur.be : 4'hf;
			// [R12] PROM window
			boot_prom_select_n   <= !in_prom;
			// [R13] I/O window
			io_window_select_n   <= !in_io;
		end
		else
		begin
			transaction_start_n <= 1'b1;
			if (st_q == smb_pkg::ST_WAIT && ready_now && last_beat)
			begin
				read_strobe_out_n    <= 1'b1;
				read_cycle_out_n     <= 1'b1;
				byte_write_strobes_n <= 4'hf;
				boot_prom_select_n   <= 1'b1;
				io_window_select_n   <= 1'b1;
			end
		end
	end

	// DRAM strobes; mux select high for row, low for column
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			dram_row_col_select  <= 1'b1;
			dram_row_strobe_n    <= 1'b1;
			dram_col_strobe_n    <= 1'b1;
			dram_output_enable_n <= 1'b1;
		end
		else
		begin
			// [R3] [R8] row phase; select drops with the column phase
			dram_row_col_select <= !((st_q == smb_pkg::ST_COL) ||
				(st_q == smb_pkg::ST_WAIT && hold_q.dram));
			dram_row_strobe_n   <= !((st_q == smb_pkg::ST_ROW) ||
				(st_q == smb_pkg::ST_COL) ||
				(st_q == smb_pkg::ST_WAIT && hold_q.dram));
			// [R23] column phase
			dram_col_strobe_n   <= !((st_q == smb_pkg::ST_COL) ||
				(st_q == smb_pkg::ST_WAIT && hold_q.dram));
			// [R4] [R17] own DRAM read or DMA read
			dram_output_enable_n <= !((hold_q.dram && !hold_q.write &&
				(st_q == smb_pkg::ST_COL || st_q == smb_pkg::ST_WAIT)) ||
				(bus_granted && !rdi_q));
		end
	end

	// Read capture and parity check on each ready
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			rbuf_q     <= '0;
			perr_acc_q <= 1'b0;
		end
		else if (fifo_take)
			perr_acc_q <= 1'b0;
		else if (st_q == smb_pkg::ST_WAIT && ready_now && !hold_q.write)
		begin
			// [R2] narrow data only from bits 7:0
			if (narrow_q)
				rbuf_q[8*lane +: 8] <= data_in[7:0];
			else
				rbuf_q <= data_in;
			// [R5] [R6] [R15] check only when enabled
			if (!pen_q && (word_par(data_in) != parity_in))
				perr_acc_q <= 1'b1;
		end
	end

	// Error pulse, sticky status and read answer
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			parity_error  <= 1'b0;
			parity_status <= 1'b0;
			rsp_valid     <= 1'b0;
			rsp           <= '0;
		end
		else
		begin
			// [R24] [R7] one-cycle error after final ready
			parity_error <= (st_q == smb_pkg::ST_DONE) && perr_acc_q;
			if (st_q == smb_pkg::ST_DONE && perr_acc_q)
				parity_status <= 1'b1;
			if (st_q == smb_pkg::ST_DONE && !hold_q.write)
			begin
				rsp_valid  <= 1'b1;
				rsp.rdata  <= rbuf_q;
				rsp.perr   <= perr_acc_q;
			end
			else if (rsp_ready)
				rsp_valid <= 1'b0;
		end
	end

	// [R19] snoop: cacheable write by another master invalidates
	always_ff @(posedge clock)
	begin
		if (!nrst)
			snoop_invalidate <= 1'b0;
		else
			snoop_invalidate <= bus_granted && !csh_q && !sst_q && rti_q;
	end
endmodule
`default_nettype wire

//--- dv/smb_bus_if_assertions.sv
// Pin-level checks bound to the memory bus interface
`timescale 1ns/1ps
`default_nettype none
module smb_bus_if_chk (
	// Clock and reset
	input wire logic		clock,
	input wire logic		nrst,
	// Bus outputs watched
	input wire logic [31:0]	addr_out,
	input wire logic [31:0]	data_out,
	input wire logic		data_out_en_n,
	input wire logic [3:0]	parity_out,
	input wire logic		transaction_start_n,
	input wire logic		read_strobe_out_n,
	input wire logic		read_cycle_out_n,
	input wire logic [3:0]	byte_write_strobes_n,
	input wire logic		boot_prom_select_n,
	input wire logic		io_window_select_n,
	input wire logic		parity_error,
	input wire logic		parity_status,
	input wire logic		dram_row_col_select,
	input wire logic		dram_row_strobe_n,
	input wire logic		dram_col_strobe_n
);
	// One clock domain, so clocking and reset are shared
	default clocking @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// Window decode and lane parity worked out from the pins
	wire logic in_prom = addr_out >= smb_pkg::PROM_BASE
		&& addr_out <= smb_pkg::PROM_LAST;
	wire logic in_io = addr_out >= smb_pkg::IO_BASE
		&& addr_out <= smb_pkg::IO_LAST;
	wire logic [3:0] even_par = {^data_out[31:24], ^data_out[23:16],
		^data_out[15:8], ^data_out[7:0]};
	start_once_a:
	assert property ($fell(transaction_start_n) |=> transaction_start_n)
		else $error("start strobe longer than one cycle");
	prom_window_a:
	assert property (!transaction_start_n |-> boot_prom_select_n == !in_prom)
		else $error("boot select wrong at start");
	io_window_a:
	assert property (!transaction_start_n |-> io_window_select_n == !in_io)
		else $error("io select wrong at start");
	parity_gen_a:
	assert property (!data_out_en_n |-> parity_out == even_par)
		else $error("write parity not even");
	perr_pulse_a:
	assert property (parity_error |=> !parity_error)
		else $error("parity error longer than one cycle");
	status_post_a:
	assert property (parity_error |-> ##[0:1] parity_status)
		else $error("parity status not posted");
	read_strobe_a:
	assert property (!read_strobe_out_n |->
		!read_cycle_out_n && &byte_write_strobes_n)
		else $error("read strobe outside a read");
	write_lane_a:
	assert property (!(&byte_write_strobes_n) |->
		read_cycle_out_n && !data_out_en_n)
		else $error("write strobe without driven data");
	row_phase_a:
	assert property ($fell(dram_row_strobe_n) |-> dram_row_col_select)
		else $error("row strobe with column select");
	col_phase_a:
	assert property ($fell(dram_col_strobe_n) |->
		!dram_row_col_select && !dram_row_strobe_n)
		else $error("column strobe with row select");
endmodule
bind smb_bus_if smb_bus_if_chk smb_bus_if_chk_inst (
	.clock, .nrst, .addr_out, .data_out, .data_out_en_n, .parity_out,
	.transaction_start_n, .read_strobe_out_n, .read_cycle_out_n,
	.byte_write_strobes_n, .boot_prom_select_n, .io_window_select_n,
	.parity_error, .parity_status, .dram_row_col_select,
	.dram_row_strobe_n, .dram_col_strobe_n
);
`default_nettype wire

//--- dv/smb_mem_model.sv
// Behavioural memory standing on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module smb_mem_model (
	// Clock
	input wire logic		clock,
	// Bus from the interface
	input wire logic [31:0]	addr_out,
	input wire logic [31:0]	data_out,
	input wire logic [3:0]	byte_write_strobes_n,
	input wire logic		read_cycle_out_n,
	// Behaviour chosen by the bench
	input wire logic [7:0]	delay,
	input wire logic		bad_parity,
	// Answers back to the interface
	output logic [31:0]		data_in,
	output logic [3:0]		parity_in,
	output logic			transfer_ready_n
);
	logic [31:0]	mem [16];
	logic [7:0]		cnt;
	wire logic		act = !read_cycle_out_n || byte_write_strobes_n != 4'hf;
	// Clean start: empty memory, ready released
	initial
	begin
		foreach (mem[i])
			mem[i] = 32'h0;
		data_in = 32'h0;
		cnt = 8'h0;
		transfer_ready_n = 1'b1;
	end
	// Answers a set number of cycles into the access; all ones never
	// answers, so the interface must end the access on its own
	always @(negedge clock)
	begin
		cnt <= act ? cnt + 8'h1 : 8'h0;
		transfer_ready_n <= !(act && cnt >= delay && delay != 8'hff);
		for (int b = 0; b < 4; b++)
			if (!byte_write_strobes_n[b])
				mem[addr_out[5:2]][8*b+:8] <= data_out[8*b+:8];
		// addressed byte on bits 7:0, else a changing pattern
		data_in <= !read_cycle_out_n ?
			(mem[addr_out[5:2]] >> (8 * addr_out[1:0])) : ~data_in;
	end
	// even lane parity, lane 0 broken on request
	assign parity_in = {^data_in[31:24], ^data_in[23:16], ^data_in[15:8],
		^data_in[7:0] ^ bad_parity};
endmodule
`default_nettype wire

//--- dv/test_smb_bus_if.sv
// Self-checking bench for the system memory bus interface
`timescale 1ns/1ps
`default_nettype none
module test_smb_bus_if;
	logic	clock, nrst, req_valid, req_ready, rsp_valid, rsp_ready;
	logic	auto_wait_en, parity_status, bus_granted, snoop_cacheable_n;
	logic	snoop_strobe_n, snoop_invalidate, data_out_en_n, parity_error;
	logic	transaction_start_n, read_strobe_out_n, read_cycle_out_n;
	logic	boot_prom_select_n, io_window_select_n, dram_row_col_select;
	logic	dram_output_enable_n, dram_row_strobe_n, dram_col_strobe_n;
	logic	transfer_ready_n, parity_check_enable_n, narrow_port_n;
	logic	read_strobe_in_n, read_cycle_in_n, bad_parity;
	logic	prom_low, io_low, oe_low, row_low, col_low, perr_hi;
	logic [3:0]	wait_count, parity_out, parity_in, byte_write_strobes_n;
	logic [3:0]	ws_low;
	logic [31:0]	addr_out, data_out, data_in;
	logic [7:0]	delay;
	smb_pkg::smb_req_t	req;
	smb_pkg::smb_rsp_t	rsp;
	int	fails, check_count, cyc;
	// Unit under test and the memory on its far side
	smb_bus_if smb_bus_if_inst (
		.clock, .nrst, .req_valid, .req_ready, .req, .rsp_valid,
		.rsp_ready, .rsp, .auto_wait_en, .wait_count, .parity_status,
		.bus_granted, .snoop_cacheable_n, .snoop_strobe_n,
		.snoop_invalidate, .addr_out, .data_out, .data_out_en_n,
		.parity_out, .transaction_start_n, .read_strobe_out_n,
		.read_cycle_out_n, .byte_write_strobes_n, .boot_prom_select_n,
		.io_window_select_n, .parity_error, .dram_row_col_select,
		.dram_output_enable_n, .dram_row_strobe_n, .dram_col_strobe_n,
		.data_in, .parity_in, .transfer_ready_n, .parity_check_enable_n,
		.narrow_port_n, .read_strobe_in_n, .read_cycle_in_n
	);
	smb_mem_model smb_mem_model_inst (
		.clock, .addr_out, .data_out, .byte_write_strobes_n,
		.read_cycle_out_n, .delay, .bad_parity, .data_in, .parity_in,
		.transfer_ready_n
	);
	// Free-running 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Cycle count, hang guard and sticky pin observations
	always @(posedge clock)
	begin
		cyc++;
		ws_low |= ~byte_write_strobes_n;
		prom_low |= !boot_prom_select_n;
		io_low |= !io_window_select_n;
		oe_low |= !dram_output_enable_n;
		row_low |= !dram_row_strobe_n;
		col_low |= !dram_col_strobe_n;
		perr_hi |= parity_error;
		if (cyc == 20000)
		begin
			fails++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, x);
		end
	endtask
	// One access: a write waits for its strobes, a read for its answer
	task automatic rd(input logic [31:0] a, input logic w, m,
		output logic [31:0] d, output logic e);
		{ws_low, prom_low, io_low, oe_low, row_low, col_low, perr_hi} = '0;
		req = '{a, 32'ha5c3_0f81, w ? 4'h5 : 4'hf, w, m};
		req_valid = 1'b1;
		do @(posedge clock); while (req_ready !== 1'b1);
		@(negedge clock);
		req_valid = 1'b0;
		if (w)
		begin
			wait (ws_low !== 4'h0);
			wait (byte_write_strobes_n === 4'hf);
		end
		else
		begin
			do @(posedge clock); while (rsp_valid !== 1'b1);
			d = rsp.rdata;
			e = rsp.perr;
		end
		repeat (5) @(negedge clock); // Let the ready pin settle
	endtask
	// Partial write, read back plain and through the DRAM path
	task automatic t_wr();
		logic [31:0]	d;
		logic			e;
		rd(32'h10, 1'b1, 1'b0, d, e);
		check(ws_low, 4'h5);
		rd(32'h10, 1'b0, 1'b0, d, e);
		check(d, 32'h00c3_0081);
		check(e, 1'b0);
		rd(32'h10, 1'b0, 1'b1, d, e);
		check({oe_low, row_low, col_low}, 3'h7);
		check(d, 32'h00c3_0081);
		// Narrow read from lane 2 wraps round the word
		narrow_port_n = 1'b0;
		repeat (4) @(negedge clock);
		rd(32'h12, 1'b0, 1'b0, d, e);
		check(d, 32'h00c3_0081);
		narrow_port_n = 1'b1;
		repeat (4) @(negedge clock);
		$display("write and dram test done");
	endtask
	// Window edges for both chip selects
	task automatic t_win();
		logic [31:0]	a [6] = '{32'h1f00_0000, 32'h1fff_fffc,
			32'h2000_0000, 32'h1e00_0000, 32'h1eff_fffc, 32'h1dff_fffc};
		logic [31:0]	d;
		logic			e;
		for (int i = 0; i < 6; i++)
		begin
			rd(a[i], 1'b0, 1'b0, d, e);
			check(prom_low, i < 2);
			check(io_low, i == 3 || i == 4);
		end
		$display("window test done");
	endtask
	// Parity off, bad with check on, then good
	task automatic t_par();
		logic [31:0]	d;
		logic			e;
		check(parity_status, 1'b0);
		bad_parity = 1'b1;
		rd(32'h10, 1'b0, 1'b0, d, e);
		check({e, perr_hi}, 2'h0);
		parity_check_enable_n = 1'b0;
		rd(32'h10, 1'b0, 1'b0, d, e);
		check({e, perr_hi}, 2'h3);
		bad_parity = 1'b0;
		rd(32'h10, 1'b0, 1'b0, d, e);
		check({e, perr_hi, parity_status}, 3'h1);
		parity_check_enable_n = 1'b1;
		$display("parity test done");
	endtask
	// Auto wait spacing, early ready, and a slow device outside windows
	task automatic t_wait();
		logic [7:0]	dl [5] = '{8'hff, 8'hff, 8'h01, 8'h02, 8'h14};
		logic [3:0]	wc [5] = '{4'h2, 4'h5, 4'hf, 4'h2, 4'h2};
		int			t [5];
		logic [31:0]	d;
		logic			e;
		auto_wait_en = 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			delay = dl[i];
			wait_count = wc[i];
			t[i] = cyc;
			rd(i < 3 ? 32'h1e00_0040 : 32'h100, 1'b0, 1'b0, d, e);
			t[i] = cyc - t[i];
		end
		check(t[1] - t[0], 3);
		check(t[2] - t[0] < 8, 1'b1);
		check(t[4] - t[3], 18);
		auto_wait_en = 1'b0;
		delay = 8'h02;
		$display("wait state test done");
	endtask
	// Foreign master: DMA read enable and snoop decision
	task automatic t_grant();
		{bus_granted, read_strobe_in_n, snoop_cacheable_n} = 3'h4;
		snoop_strobe_n = 1'b0;
		repeat (8) @(negedge clock);
		check({dram_output_enable_n, snoop_invalidate}, 2'h1);
		{read_cycle_in_n, read_strobe_in_n} = 2'h1;
		repeat (8) @(negedge clock);
		check({dram_output_enable_n, snoop_invalidate}, 2'h2);
		{bus_granted, read_cycle_in_n, snoop_cacheable_n} = 3'h3;
		snoop_strobe_n = 1'b1;
		$display("grant test done");
	endtask
	// Fill the queue while the bus is held, drain behind a stall
	task automatic t_fifo();
		int n;
		n = 0;
		{bus_granted, rsp_ready, req_valid} = 3'h5;
		req = '{32'h10, 32'h0, 4'hf, 1'b0, 1'b0};
		repeat (12)
		begin
			@(posedge clock);
			n += int'(req_ready === 1'b1);
		end
		@(negedge clock);
		{bus_granted, req_valid} = 2'h0;
		check(n, 8);
		repeat (40) @(negedge clock);
		rsp_ready = 1'b1;
		repeat (8)
		begin
			do @(posedge clock); while (rsp_valid !== 1'b1);
			check(rsp.rdata, 32'h00c3_0081);
		end
		repeat (60) @(negedge clock);
		check(rsp_valid, 1'b0);
		$display("queue test done");
	endtask
	// Reset, then the scenarios in turn
	initial
	begin
		{nrst, req_valid, auto_wait_en, bus_granted, bad_parity} = 5'h0;
		{rsp_ready, snoop_cacheable_n, snoop_strobe_n} = 3'h7;
		{read_strobe_in_n, read_cycle_in_n, parity_check_enable_n} = 3'h7;
		// parity check starts off, the narrow port starts unused
		narrow_port_n = 1'b1;
		req = '0;
		wait_count = 4'h0;
		delay = 8'h02;
		repeat (6) @(negedge clock);
		nrst = 1'b1;
		t_wr();
		t_win();
		t_par();
		t_wait();
		t_grant();
		t_fifo();
		print_verdict();
	end
endmodule
`default_nettype wire
